/* pkg/ahs_pkg.sv */
// package: register map, field layout and types for the hard-select sequencer
package ahs_pkg;
  localparam int unsigned AHS_NCH_HS = 8;
  localparam int unsigned AHS_NRES = 24;
  localparam int unsigned AHS_RES_W = 10;
  // byte addresses on the axi4-lite bus
  localparam logic [7:0] AHS_OFF_HS_ENABLE = 8'h00;
  localparam logic [7:0] AHS_OFF_SW_TRIG = 8'h04;
  localparam logic [7:0] AHS_OFF_STATUS = 8'h08;
  localparam logic [7:0] AHS_OFF_RESULT0 = 8'h40;
  localparam logic [7:0] AHS_OFF_RESULT_LAST = 8'h9c;
  localparam logic [7:0] AHS_HS_ENABLE_RST = 8'h00;
  localparam logic [1:0] AHS_SW_TRIG_RST = 2'h0;
  // result word layout
  localparam int unsigned AHS_RES_LSB = 6;
  localparam logic [5:0] AHS_RES_FILL = 6'h3f;
  // group writes: index 12 splits the low and high group sets
  localparam logic [4:0] AHS_GROUP_SPLIT = 5'h0c;
  localparam logic [1:0] AHS_RESP_OKAY = 2'h0;
  localparam logic [1:0] AHS_RESP_SLVERR = 2'h2;
  // modes of the converter
  typedef enum logic [1:0] {AHS_M_IDLE, AHS_M_SCAN, AHS_M_SEL, AHS_M_HS} ahs_mode_t;
  typedef struct packed {
    logic [4:0] chan;
    logic [AHS_RES_W-1:0] data;
    logic valid;
  } ahs_result_t;
  typedef struct packed {
    logic start;
    logic [4:0] chan;
    ahs_mode_t mode;
  } ahs_conv_t;
endpackage

/* rtl/ahs_result_bank.sv */
// result register bank with group writes and left-justified reads
`timescale 1ns/1ps
module ahs_result_bank (
  // clock
  input wire logic clk_sys_i,
  input wire logic ce_i,
  // converter side
  input wire ahs_pkg::ahs_result_t res_i,
  // software side
  input wire logic wr_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [4:0] rd_idx_i,
  output logic [15:0] rd_data_o
);
  import ahs_pkg::*;
  // no reset: contents stay undefined until written or converted
  logic [AHS_RES_W-1:0] mem_q [AHS_NRES]; // R6

  function automatic logic in_group(input logic [4:0] sel, input int unsigned n);
    // same parity and same half (0-11 or 12-23) as the written index
    in_group = (sel[0] == n[0]) && ((sel >= AHS_GROUP_SPLIT) == (n >= 12));
  endfunction

  for (genvar n = 0; n < AHS_NRES; n++) begin : g_res
    always_ff @(posedge clk_sys_i) begin
      if (ce_i) begin
        if (res_i.valid && res_i.chan == 5'(n)) begin
          mem_q[n] <= res_i.data; // R3
        end else if (wr_i && in_group(wr_idx_i, n)) begin
          mem_q[n] <= wr_data_i[15:AHS_RES_LSB]; // R7 R8 R9
        end
      end
    end
  end

  // R2 R5
  assign rd_data_o = {mem_q[rd_idx_i], AHS_RES_FILL};
endmodule // ahs_result_bank

/* rtl/ahs_sequencer.sv */
// hard-select sequencer with axi4-lite registers and result bank
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// R1 - enable bits 0-3 gate channels 0-3, bits 4-7 gate channels 12-15
// R2 - 10-bit result sits in bits 15 down to 6 of the word
// R3 - result of channel n goes to result register n
// R4 - software accesses results as full words only
// R5 - reads return result left-justified with low six bits as ones
// R6 - result registers have no reset
// R7 - write to 0 or 1 updates its even/odd group 0-11
// R8 - write to 12 or 13 updates its even/odd group 12-23
// R9 - no single result register can be written alone
// R10 - flag set on marker after event, hard select starts one clock later
// R11 - same edge on two channels: lower number first, next one clock later
// R12 - hard select suspends select mode, which resumes afterwards
// R13 - select suspends scan at once, scan resumes one clock after select
// R14 - lower-priority request waits, starts one clock after higher completes
// R15 - higher-priority request suspends lower, lower resumes one clock after
// R16 - priority falls with ascending channel number
// R17 - enable register resets to zero
// R18 - software trigger acts on rising edge, held while hard select busy
module ahs_sequencer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // event sources and core timing
  input wire logic [7:0] hs_event_i,
  input wire logic cpu_cycle_marker_pulse_i,
  input wire logic scan_req_i,
  input wire logic [4:0] scan_chan_i,
  input wire logic sel_req_i,
  input wire logic [4:0] sel_chan_i,
  // converter core
  input wire logic conv_done_i,
  input wire logic [9:0] conv_data_i,
  output ahs_pkg::ahs_conv_t conv_o,
  output logic [7:0] interrupt_request_flag_o
);
  import ahs_pkg::*;

  typedef struct packed {
    logic awr;
    logic [7:0] awaddr;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] hs_enable;
    logic [1:0] sw_trig;
    logic [1:0] sw_trig_old;
    logic [7:0] ev_pend;
    logic [7:0] interrupt_request_flag;
    logic [7:0] hs_pend;
    logic [2:0] hs_cur;
    logic hs_busy;
    logic sel_act;
    logic sel_susp;
    logic [4:0] sel_chan;
    logic scan_act;
    logic scan_susp;
    logic [4:0] scan_chan;
    ahs_mode_t mode;
    logic [4:0] chan;
    logic gap;
    ahs_conv_t conv;
  } ahs_state_t;

  ahs_state_t s_q, s_d;

  logic wr_fire, rd_fire, res_wr;
  logic [15:0] bank_rd;
  ahs_result_t res;
  logic [7:0] hs_trig;
  logic [7:0] req_hi;

  // slot i of the enable register maps to an analog channel number
  function automatic logic [4:0] slot_chan(input logic [2:0] i);
    slot_chan = i[2] ? 5'(i) + 5'h08 : 5'(i); // R1
  endfunction

  function automatic logic [2:0] first_set(input logic [7:0] v);
    first_set = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i); // R16
      end
    end
  endfunction

  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= AHS_OFF_RESULT0) && (a <= AHS_OFF_RESULT_LAST);
  endfunction

  function automatic logic [4:0] res_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - AHS_OFF_RESULT0;
    res_idx = d[6:2];
  endfunction

  assign wr_fire = s_q.awr && s_q.wr && !s_q.bvalid;
  assign rd_fire = s_arvalid_i && !s_q.rvalid;
  // word only: both low byte lanes must be enabled
  assign res_wr = wr_fire && is_result(s_q.awaddr) && (s_q.wstrb[1:0] == 2'h3); // R4
  // software bits act like channel 0/1 events on rising edge
  assign hs_trig = hs_event_i | {6'h00, s_q.sw_trig & ~s_q.sw_trig_old}; // R18

  assign res.valid = conv_done_i && (s_q.mode != AHS_M_IDLE) && !s_q.gap;
  assign res.chan = s_q.chan;
  assign res.data = conv_data_i;

  ahs_result_bank u_bank (
    .clk_sys_i(clk_sys_i),
    .ce_i(ce_i),
    .res_i(res),
    .wr_i(res_wr),
    .wr_idx_i(res_idx(s_q.awaddr)),
    .wr_data_i(s_q.wdata[15:0]),
    .rd_idx_i(res_idx(s_araddr_i)),
    .rd_data_o(bank_rd)
  );

  always_comb begin
    s_d = s_q;
    s_d.conv.start = 1'b0;
    req_hi = 8'h00;
    // bus channels
    if (s_awvalid_i && !s_q.awr) begin
      s_d.awr = 1'b1;
      s_d.awaddr = s_awaddr_i;
    end
    if (s_wvalid_i && !s_q.wr) begin
      s_d.wr = 1'b1;
      s_d.wdata = s_wdata_i;
      s_d.wstrb = s_wstrb_i;
    end
    if (wr_fire) begin
      s_d.awr = 1'b0;
      s_d.wr = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = AHS_RESP_OKAY;
      case (s_q.awaddr)
        AHS_OFF_HS_ENABLE: begin
          if (s_q.wstrb[0]) s_d.hs_enable = s_q.wdata[7:0]; // R1
        end
        AHS_OFF_SW_TRIG: begin
          if (s_q.wstrb[0]) s_d.sw_trig = s_q.wdata[1:0];
        end
        default: begin
          if (!res_wr) s_d.bresp = AHS_RESP_SLVERR; // R4
        end
      endcase
    end
    if (s_q.bvalid && s_bready_i) s_d.bvalid = 1'b0;
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = AHS_RESP_OKAY;
      s_d.rdata = 32'h0;
      if (s_araddr_i == AHS_OFF_HS_ENABLE) s_d.rdata = {24'h0, s_q.hs_enable};
      else if (s_araddr_i == AHS_OFF_SW_TRIG) s_d.rdata = {30'h0, s_q.sw_trig};
      else if (s_araddr_i == AHS_OFF_STATUS) begin
        s_d.rdata = {16'h0, s_q.hs_pend, 3'h0, s_q.hs_busy, s_q.sel_act,
                     s_q.scan_act, s_q.mode};
      end else if (is_result(s_araddr_i)) s_d.rdata = {16'h0, bank_rd}; // R5
      else s_d.rresp = AHS_RESP_SLVERR;
    end
    if (s_q.rvalid && s_rready_i) s_d.rvalid = 1'b0;
    // events latch until the marker, then raise the request flag
    s_d.sw_trig_old = s_q.sw_trig;
    s_d.ev_pend = s_q.ev_pend | (hs_trig & s_q.hs_enable); // R1
    s_d.interrupt_request_flag = 8'h00;
    if (cpu_cycle_marker_pulse_i) begin
      s_d.interrupt_request_flag = s_d.ev_pend; // R10
      s_d.ev_pend = 8'h00;
    end
    // flagged channels join the hard-select pending set (held while busy)
    s_d.hs_pend = s_q.hs_pend | s_q.interrupt_request_flag; // R14 R18
    // software and scan requests
    if (sel_req_i && !s_q.sel_act) begin
      s_d.sel_act = 1'b1;
      s_d.sel_chan = sel_chan_i;
    end
    if (scan_req_i && !s_q.scan_act) begin
      s_d.scan_act = 1'b1;
      s_d.scan_chan = scan_chan_i;
    end
    // completion of the running conversion
    s_d.gap = 1'b0;
    if (conv_done_i && !s_q.gap) begin
      case (s_q.mode)
        AHS_M_HS: begin
          // pending bits stay: a request reserved during this run starts next
          s_d.hs_busy = 1'b0;
        end
        AHS_M_SEL: s_d.sel_act = 1'b0;
        AHS_M_SCAN: s_d.scan_act = 1'b0;
        default: ;
      endcase
      if (s_q.mode != AHS_M_IDLE) begin
        s_d.mode = AHS_M_IDLE;
        s_d.gap = 1'b1; // next work starts one clock later R11 R13 R14 R15
      end
    end
    // arbitration: hard select, then select, then scan
    for (int i = 0; i < 8; i++) begin
      if (i < s_q.hs_cur) req_hi[i] = s_q.interrupt_request_flag[i];
    end
    if (s_d.mode == AHS_M_HS && !s_d.gap && |req_hi) begin
      s_d.hs_pend[s_q.hs_cur] = 1'b1; // R15
      s_d.mode = AHS_M_IDLE;
    end
    if ((s_d.mode == AHS_M_SEL || s_d.mode == AHS_M_SCAN) && |s_q.interrupt_request_flag) begin
      s_d.mode = AHS_M_IDLE; // R12
    end
    if (s_d.mode == AHS_M_SCAN && sel_req_i) begin
      s_d.mode = AHS_M_IDLE; // R13
      s_d.gap = 1'b1; // select starts one clock after the suspend
    end
    if (s_d.mode == AHS_M_IDLE && !s_d.gap) begin
      // flags of this clock count already, so the start trails the flag by one
      if (|s_d.hs_pend) begin
        s_d.hs_cur = first_set(s_d.hs_pend); // R11 R16
        s_d.hs_pend[s_d.hs_cur] = 1'b0;
        s_d.hs_busy = 1'b1;
        s_d.mode = AHS_M_HS;
        s_d.chan = slot_chan(s_d.hs_cur); // R10 R12 R15
      end else if (s_q.sel_act) begin
        s_d.mode = AHS_M_SEL;
        s_d.chan = s_q.sel_chan; // R12
      end else if (s_q.scan_act) begin
        s_d.mode = AHS_M_SCAN;
        s_d.chan = s_q.scan_chan; // R13
      end
      if (s_d.mode != AHS_M_IDLE) begin
        s_d.conv.start = 1'b1;
      end
    end
    s_d.conv.chan = s_d.chan;
    s_d.conv.mode = s_d.mode;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.hs_enable <= AHS_HS_ENABLE_RST; // R17
      s_q.sw_trig <= AHS_SW_TRIG_RST;
      s_q.mode <= AHS_M_IDLE;
      s_q.conv.mode <= AHS_M_IDLE;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign s_awready_o = !s_q.awr;
  assign s_wready_o = !s_q.wr;
  assign s_bvalid_o = s_q.bvalid;
  assign s_bresp_o = s_q.bresp;
  assign s_arready_o = !s_q.rvalid;
  assign s_rvalid_o = s_q.rvalid;
  assign s_rdata_o = s_q.rdata;
  assign s_rresp_o = s_q.rresp;
  assign conv_o = s_q.conv;
  assign interrupt_request_flag_o = s_q.interrupt_request_flag;

  // a hard-select conversion starts exactly one clock after its flag
  a_hs_start_after_flag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R10
    (ce_i && |s_q.interrupt_request_flag && s_q.mode == AHS_M_IDLE && !s_q.gap && !s_q.hs_busy)
      |=> (s_q.mode == AHS_M_HS && s_q.conv.start))
    else $error("hard select did not start one clock after flag");
  // a completed conversion leaves one idle clock before the next start
  a_gap_after_done: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R11
    (ce_i && conv_done_i && s_q.mode != AHS_M_IDLE && !s_q.gap)
      |=> (s_q.mode == AHS_M_IDLE && !s_q.conv.start))
    else $error("no one-clock gap after conversion end");
  // enable bits gate the flag
  a_flag_needs_enable: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R1
    (s_q.interrupt_request_flag & ~$past(s_q.hs_enable, 2)) == 8'h00 || !$past(ce_i))
    else $error("flag raised for disabled channel");
  // flags only rise on the marker
  a_flag_on_marker: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R10
    (ce_i && |s_d.interrupt_request_flag) |-> cpu_cycle_marker_pulse_i)
    else $error("flag set without marker");
  // select never runs while hard-select work waits at arbitration
  a_hs_over_sel: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R12
    (ce_i && s_q.conv.start && s_q.mode == AHS_M_SEL) |-> !$past(|s_q.hs_pend))
    else $error("select started over pending hard select");
  // scan yields to a select request at once
  a_scan_yields: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R13
    (ce_i && s_q.mode == AHS_M_SCAN && sel_req_i && !(conv_done_i && !s_q.gap))
      |=> s_q.mode == AHS_M_IDLE ##1 s_q.mode == AHS_M_SEL)
    else $error("scan not suspended for select");
  // result reads fill the low bits with ones
  a_result_fill: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R5
    (ce_i && rd_fire && is_result(s_araddr_i)) |=> s_q.rdata[5:0] == AHS_RES_FILL)
    else $error("result low bits not ones");
  // enable register reads back what was written
  a_enable_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R17
    (ce_i && wr_fire && s_q.awaddr == AHS_OFF_HS_ENABLE && s_q.wstrb[0])
      |=> s_q.hs_enable == $past(s_q.wdata[7:0]))
    else $error("enable register not updated");
endmodule // ahs_sequencer

/* sim/ahs_core_model.sv */
// behavioural converter core answering conversion starts
`timescale 1ns/1ps
module ahs_core_model #(
  parameter int unsigned LAT = 12
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire ahs_pkg::ahs_conv_t conv_i,
  output logic conv_done_o,
  output logic [9:0] conv_data_o
);
  import ahs_pkg::*;
  int cnt;
  logic [4:0] chan_q;
  // a new start abandons the running one, as a suspend does
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 0;
      chan_q <= 5'h00;
      conv_done_o <= 1'b0;
      conv_data_o <= 10'h155;
    end else begin
      conv_done_o <= 1'b0;
      // data only valid with done, so it toggles otherwise
      conv_data_o <= ~conv_data_o;
      if (conv_i.start) begin
        cnt <= LAT;
        chan_q <= conv_i.chan;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_done_o <= 1'b1;
        conv_data_o <= {chan_q, ~chan_q};
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // ahs_core_model

/* sim/testbench.sv */
// self-checking bench for the hard-select sequencer
`timescale 1ns/1ps
module testbench;
  import ahs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] ev = 8'h00;
  logic [7:0] flag;
  logic marker = 1'b0, scan_req = 1'b0, sel_req = 1'b0;
  logic [4:0] scan_chan = 5'h00, sel_chan = 5'h00;
  logic [9:0] cdata;
  ahs_conv_t conv;
  int err_count = 0;
  int n_tests = 0;
  int seed = 32'h8329;
  logic [15:0] vg [4];
  logic [6:0] sq [$];
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  logic [33:0] re;
  initial forever #4 clk_sys_i = ~clk_sys_i;
  ahs_sequencer ahs_sequencer_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata),
    .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp),
    .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
    .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
    .s_rready_i(rready), .hs_event_i(ev), .cpu_cycle_marker_pulse_i(marker),
    .scan_req_i(scan_req), .scan_chan_i(scan_chan), .sel_req_i(sel_req),
    .sel_chan_i(sel_chan), .conv_done_i(done), .conv_data_i(cdata), .conv_o(conv),
    .interrupt_request_flag_o(flag));
  ahs_core_model ahs_core_model_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .conv_i(conv),
    .conv_done_o(done), .conv_data_o(cdata));
  task automatic finish_test;
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  function automatic logic [7:0] ra(input int i);
    return 8'(AHS_OFF_RESULT0 + 4 * i);
  endfunction
  function automatic logic [6:0] h(input logic [4:0] c);
    return {c, AHS_M_HS};
  endfunction
  function automatic logic [15:0] rv(input logic [4:0] c);
    return {c, ~c, AHS_RES_FILL};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk_sys_i);
      if (pa && awready) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(posedge clk_sys_i); while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] d,
                    input logic [1:0] r);
    rq.push_back({r, m, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys_i); while (!rvalid);
  endtask
  task automatic mark;
    marker <= 1'b1;
    cyc(1);
    marker <= 1'b0;
  endtask
  // marker comes two cycles after the event so the wait is visible
  task automatic fire(input logic [7:0] s);
    ev <= s;
    cyc(1);
    ev <= 8'h00;
    cyc(2);
    mark;
  endtask
  task automatic drain;
    int k;
    k = 0;
    while (sq.size() != 0 && k < 400) begin
      cyc(1);
      k++;
    end
    cyc(24);
    chk(sq.size(), 0);
  endtask
  always @(negedge clk_sys_i) begin
    if (bvalid && bready) chk(bresp, bq.size() ? bq.pop_front() : 2'bxx);
    if (rvalid && rready) begin
      re = rq.size() ? rq.pop_front() : 'x;
      chk({rresp, rdata[15:0] & re[31:16]}, {re[33:32], re[15:0]});
    end
    // a start nobody announced finds the queue empty and fails
    if (conv.start) chk({conv.chan, conv.mode}, sq.size() ? sq.pop_front() : 7'bx);
  end
  initial begin
    #(8 * 60000);
    err_count++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(AHS_OFF_HS_ENABLE, 16'h00ff, {8'h00, AHS_HS_ENABLE_RST}, AHS_RESP_OKAY);
    rd(8'h30, 16'h0000, 16'h0000, AHS_RESP_SLVERR);
    fire(8'h01);
    cyc(30);
    wr(AHS_OFF_HS_ENABLE, 32'hff, 4'h1, AHS_RESP_OKAY);
    rd(AHS_OFF_HS_ENABLE, 16'h00ff, 16'h00ff, AHS_RESP_OKAY);
    sq.push_back(h(0));
    sq.push_back(h(1));
    fire(8'h03);
    @(negedge clk_sys_i);
    chk(flag, 8'h03);
    @(negedge clk_sys_i);
    chk(conv.start, 1'b1);
    @(posedge clk_sys_i);
    drain;
    rd(ra(0), 16'hffff, rv(0), AHS_RESP_OKAY);
    rd(ra(1), 16'hffff, rv(1), AHS_RESP_OKAY);
    sq.delete();
    sq = '{{5'h05, AHS_M_SCAN}, {5'h07, AHS_M_SEL}, h(0), {5'h07, AHS_M_SEL}, {5'h05, AHS_M_SCAN}};
    scan_chan <= 5'h05;
    scan_req <= 1'b1;
    cyc(1);
    scan_req <= 1'b0;
    cyc(3);
    sel_chan <= 5'h07;
    sel_req <= 1'b1;
    cyc(1);
    sel_req <= 1'b0;
    cyc(3);
    fire(8'h01);
    drain;
    sq = '{h(1), h(0), h(1)};
    fire(8'h02);
    cyc(3);
    fire(8'h01);
    drain;
    sq = '{h(0), h(1)};
    fire(8'h01);
    cyc(3);
    fire(8'h02);
    drain;
    sq = '{h(12)};
    fire(8'h10);
    drain;
    rd(ra(12), 16'hffff, rv(12), AHS_RESP_OKAY);
    sq = '{h(0)};
    wr(AHS_OFF_SW_TRIG, 32'h1, 4'h1, AHS_RESP_OKAY);
    mark;
    drain;
    // level held high must not start a second conversion
    wr(AHS_OFF_SW_TRIG, 32'h1, 4'h1, AHS_RESP_OKAY);
    mark;
    cyc(30);
    wr(AHS_OFF_SW_TRIG, 32'h0, 4'h1, AHS_RESP_OKAY);
    sq = '{h(0)};
    wr(AHS_OFF_SW_TRIG, 32'h1, 4'h1, AHS_RESP_OKAY);
    mark;
    drain;
    foreach (vg[g]) begin
      vg[g] = 16'($random(seed));
      wr(ra(g < 2 ? g : g + 10), {16'h0, vg[g]}, 4'hf, AHS_RESP_OKAY);
      if (g == 0) rd(ra(1), 16'hffff, rv(1), AHS_RESP_OKAY);
      for (int k = 0; k < 6; k++)
        rd(ra((g < 2 ? g : g + 10) + 2 * k), 16'hffff, {vg[g][15:6], AHS_RES_FILL},
           AHS_RESP_OKAY);
    end
    wr(ra(0), 32'h0000ffc0, 4'h1, AHS_RESP_SLVERR);
    rd(ra(2), 16'hffff, {vg[0][15:6], AHS_RES_FILL}, AHS_RESP_OKAY);
    cyc(4);
    finish_test;
  end
endmodule // testbench
